// >>> verilog/rtc_defines.vh
// Constants for the real-time clock control, alarm flag and serial slave block.
// Assumes a single clk_sys domain; included by bare name from each design file.
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH

`define RTC_SYNC_W 4
`define RTC_SI_CE 0
`define RTC_SI_SCLK 1
`define RTC_SI_DIN 2
`define RTC_SI_STRAP 3

`define RTC_A_CTRL 7'h0f
`define RTC_A_STAT 7'h10
`define RTC_A_CHG 7'h11
`define RTC_A_AL0_LO 7'h07
`define RTC_A_AL0_HI 7'h0a
`define RTC_A_AL1_LO 7'h0b
`define RTC_A_AL1_HI 7'h0e
`define RTC_A_CLK_TOP 5'h1f
`define RTC_A_RAM_TOP 7'h7f
`define RTC_A_RAM_BASE 7'h20
`define RTC_A_ZERO 7'h00
`define RTC_A_ONE 7'h01

`define RTC_B_OSC 7
`define RTC_B_WP 6
`define RTC_B_SEL 2
`define RTC_B_IE1 1
`define RTC_B_IE0 0
`define RTC_B_DIR 7

`define RTC_RST_OSC 1'b1
`define RTC_RST_WP 1'b0
`define RTC_RST_CHG 8'h5c
`define RTC_UNLOCK 4'ha
`define RTC_DS_ONE 2'h1
`define RTC_DS_TWO 2'h2
`define RTC_RS_OFF 2'h0
`define RTC_BIT_LAST 3'h7

`endif

// >>> verilog/rtc_sync.v
// Two-flop synchroniser bank for the serial pins and the strap.
// Assumes every input is asynchronous to clk_sys.
`default_nettype none
`include "rtc_defines.vh"
module rtc_sync (
   input wire clk_sys,
   input wire rst,
   input wire [`RTC_SYNC_W-1:0] async_in,
   output wire [`RTC_SYNC_W-1:0] sync_out
);
   reg [`RTC_SYNC_W-1:0] meta;
   reg [`RTC_SYNC_W-1:0] stable;
   genvar i;
   generate
      for (i = 0; i < `RTC_SYNC_W; i = i + 1) begin : g_bit
         always @(posedge clk_sys) begin
            if (rst) begin
               meta[i] <= 1'b0;
               stable[i] <= 1'b0;
            end else begin
               meta[i] <= async_in[i];
               stable[i] <= meta[i];
            end
         end
      end
   endgenerate
   assign sync_out = stable;
endmodule
`default_nettype wire

// >>> verilog/rtc_serial_top.v
// Serial slave port, control, status and charger-select registers of the clock.
// Assumes the host supplies chip enable and serial clock far slower than clk_sys,
// and that timekeeping, alarm compare and RAM sit behind the ext_* port.
// The serial clock half-period must cover at least four clk_sys cycles, since
// every pin crosses two flops and edges are found by comparing synced levels.
`default_nettype none
`include "rtc_defines.vh"
module rtc_serial_top (
   input wire clk_sys,
   input wire rst,
   input wire chip_enable,
   input wire sclk,
   input wire serial_in,
   output reg serial_out,
   output reg serial_out_oe,
   input wire interface_select_strap,
   input wire primary_supply_valid,
   input wire alarm0_match,
   input wire alarm1_match,
   output reg irq_out_first_n,
   output reg irq_out_second_n,
   output reg oscillator_disable,
   output reg charger_enable,
   output reg charger_two_diodes,
   output reg [1:0] charger_resistor,
   output reg [6:0] ext_addr,
   output reg [7:0] ext_wdata,
   output reg ext_we,
   output reg ext_re,
   input wire [7:0] ext_rdata
);
   wire [`RTC_SYNC_W-1:0] pins_s;
   wire ce_s;
   wire sclk_s;
   wire din_s;
   wire strap_s;
   reg ce_d;
   reg sclk_d;
   reg idle_pol;
   reg mode_spi;
   reg [2:0] bit_cnt;
   reg [7:0] rx_sh;
   reg [7:0] tx_sh;
   reg got_addr;
   reg is_write;
   reg [6:0] ptr;
   reg load_pend;
   reg reading;
   reg write_protect;
   reg alarm_output_select;
   reg alarm0_irq_enable;
   reg alarm1_irq_enable;
   reg alarm0_flag;
   reg alarm1_flag;
   reg [7:0] charger_select;
   reg [7:0] next_byte;
   reg [6:0] next_ptr;
   reg [7:0] rd_mux;
   reg touch0;
   reg touch1;
   wire ce_rise;
   wire sclk_edge;
   wire strobe;
   wire shift;
   wire byte_done;
   wire wr_ok;
   wire [3:0] unlock_f;
   wire [1:0] diode_f;
   wire [1:0] res_f;
   wire [6:0] touch_addr;
   wire alarm0_live;
   wire alarm1_live;
   wire diode_ok;
   wire next_irq_first_n;
   wire next_irq_second_n;
   wire next_charger_enable;
   wire next_charger_two_diodes;

   // Strap, data, clock and enable all cross into clk_sys with the same latency
   rtc_sync u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in({interface_select_strap, serial_in, sclk, chip_enable}),
      .sync_out(pins_s)
   );
   assign ce_s = pins_s[`RTC_SI_CE];
   assign sclk_s = pins_s[`RTC_SI_SCLK];
   assign din_s = pins_s[`RTC_SI_DIN];
   assign strap_s = pins_s[`RTC_SI_STRAP];

   // Edges count only after chip enable has stood high for a cycle
   assign ce_rise = ce_s & ~ce_d;
   assign sclk_edge = ce_s & ce_d & (sclk_s ^ sclk_d);
   // SPI strobes on the edge back to idle level; 3-wire strobes on rising edge
   assign strobe = sclk_edge & (mode_spi ? (sclk_s == idle_pol) : sclk_s);
   assign shift = sclk_edge & (mode_spi ? (sclk_s != idle_pol) : ~sclk_s);
   assign byte_done = strobe & (bit_cnt == `RTC_BIT_LAST);
   assign wr_ok = primary_supply_valid & ~write_protect;

   // MSB first in SPI, LSB first on the 3-wire line
   always @* begin
      if (mode_spi)
         next_byte = {rx_sh[6:0], din_s};
      else
         next_byte = {din_s, rx_sh[7:1]};
   end

   // Burst wrap stays inside the clock area or the RAM area
   // Write addresses share the low seven bits, so one wrap serves both directions
   always @* begin
      if (ptr[6:5] == 2'h0 && ptr[4:0] == `RTC_A_CLK_TOP)
         next_ptr = `RTC_A_ZERO;
      else if (ptr == `RTC_A_RAM_TOP)
         next_ptr = `RTC_A_RAM_BASE;
      else
         next_ptr = ptr + `RTC_A_ONE;
   end

   // Local registers answer here; time, alarm, reserved and RAM come from ext_rdata
   always @* begin
      case (ext_addr)
         `RTC_A_CTRL: rd_mux = {oscillator_disable, write_protect, 3'h0,
            alarm_output_select, alarm1_irq_enable, alarm0_irq_enable};
         `RTC_A_STAT: rd_mux = {6'h00, alarm1_flag, alarm0_flag};
         `RTC_A_CHG: rd_mux = charger_select;
         default: rd_mux = ext_rdata;
      endcase
   end

   // The pointer touches an address on the address byte and on each increment
   assign touch_addr = got_addr ? next_ptr : next_byte[6:0];
   always @* begin
      touch0 = 1'b0;
      touch1 = 1'b0;
      if (byte_done) begin
         touch0 = (touch_addr >= `RTC_A_AL0_LO) && (touch_addr <= `RTC_A_AL0_HI);
         touch1 = (touch_addr >= `RTC_A_AL1_LO) && (touch_addr <= `RTC_A_AL1_HI);
      end
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         ce_d <= 1'b0;
         sclk_d <= 1'b0;
         idle_pol <= 1'b0;
         mode_spi <= 1'b1;
         bit_cnt <= 3'h0;
         rx_sh <= 8'h00;
         tx_sh <= 8'h00;
         got_addr <= 1'b0;
         is_write <= 1'b0;
         ptr <= `RTC_A_ZERO;
         load_pend <= 1'b0;
         reading <= 1'b0;
         serial_out <= 1'b0;
         serial_out_oe <= 1'b0;
         ext_addr <= `RTC_A_ZERO;
         ext_wdata <= 8'h00;
         ext_we <= 1'b0;
         ext_re <= 1'b0;
      end else begin
         ce_d <= ce_s;
         sclk_d <= sclk_s;
         ext_we <= 1'b0;
         ext_re <= 1'b0;
         load_pend <= 1'b0;
         // Polarity and mode are frozen for the whole frame
         if (ce_rise) begin
            idle_pol <= sclk_s;
            mode_spi <= strap_s;
            bit_cnt <= 3'h0;
            got_addr <= 1'b0;
            reading <= 1'b0;
         end
         // Deselect releases the line and drops any partial byte at once
         if (~ce_s) begin
            serial_out_oe <= 1'b0;
            serial_out <= 1'b0;
            reading <= 1'b0;
            bit_cnt <= 3'h0;
            got_addr <= 1'b0;
         end
         if (strobe) begin
            rx_sh <= next_byte;
            bit_cnt <= bit_cnt + 3'h1;
         end
         if (byte_done) begin
            // First byte of a frame: direction from the top bit, pointer from the rest
            if (~got_addr) begin
               got_addr <= 1'b1;
               is_write <= next_byte[`RTC_B_DIR];
               ptr <= next_byte[6:0];
               ext_addr <= next_byte[6:0];
               if (~next_byte[`RTC_B_DIR]) begin
                  load_pend <= 1'b1;
                  ext_re <= 1'b1;
               end
            end else begin
               ptr <= next_ptr;
               // Writes land at the current pointer; reads fetch the next one ahead
               if (is_write) begin
                  ext_addr <= ptr;
                  ext_wdata <= next_byte;
                  ext_we <= wr_ok;
               end else begin
                  ext_addr <= next_ptr;
                  load_pend <= 1'b1;
                  ext_re <= 1'b1;
               end
            end
         end
         // Data is picked up one cycle after the pointer settles on ext_addr
         if (load_pend & ce_s) begin
            tx_sh <= rd_mux;
            reading <= 1'b1;
         end
         if (shift & reading) begin
            serial_out_oe <= 1'b1;
            if (mode_spi) begin
               serial_out <= tx_sh[7];
               tx_sh <= {tx_sh[6:0], 1'b0};
            end else begin
               serial_out <= tx_sh[0];
               tx_sh <= {1'b0, tx_sh[7:1]};
            end
         end
      end
   end

   // Local registers take a write only at byte completion of a write burst
   // A low primary supply freezes the control and charger registers, protect bit included
   always @(posedge clk_sys) begin
      if (rst) begin
         oscillator_disable <= `RTC_RST_OSC;
         write_protect <= `RTC_RST_WP;
         alarm_output_select <= 1'b0;
         alarm0_irq_enable <= 1'b0;
         alarm1_irq_enable <= 1'b0;
         charger_select <= `RTC_RST_CHG;
      end else if (byte_done & got_addr & is_write & primary_supply_valid) begin
         if (ptr == `RTC_A_CTRL) begin
            // Protect bit stays writable so software can lift protection
            write_protect <= next_byte[`RTC_B_WP];
            if (~write_protect) begin
               oscillator_disable <= next_byte[`RTC_B_OSC];
               alarm_output_select <= next_byte[`RTC_B_SEL];
               alarm1_irq_enable <= next_byte[`RTC_B_IE1];
               alarm0_irq_enable <= next_byte[`RTC_B_IE0];
            end
         end
         if (ptr == `RTC_A_CHG && ~write_protect)
            charger_select <= next_byte;
      end
   end

   // A match in the same cycle as a pointer touch keeps the flag set
   // Matches arrive already qualified by the compare logic behind ext_*
   always @(posedge clk_sys) begin
      if (rst) begin
         alarm0_flag <= 1'b0;
         alarm1_flag <= 1'b0;
      end else begin
         alarm0_flag <= alarm0_match | (alarm0_flag & ~touch0);
         alarm1_flag <= alarm1_match | (alarm1_flag & ~touch1);
      end
   end

   assign unlock_f = charger_select[7:4];
   assign diode_f = charger_select[3:2];
   assign res_f = charger_select[1:0];

   // An enabled flag pulls its pin; the select bit steers alarm 1 between the pins
   assign alarm0_live = alarm0_flag & alarm0_irq_enable;
   assign alarm1_live = alarm1_flag & alarm1_irq_enable;
   assign next_irq_first_n = ~(alarm0_live | (~alarm_output_select & alarm1_live));
   // With select low the second pin stays released whatever alarm 1 does
   assign next_irq_second_n = ~(alarm_output_select & alarm1_live);

   // All three fields must hold a legal code; any other pattern leaves the charger off
   // The unlock nibble guards against a single corrupted write turning it on
   assign diode_ok = (diode_f == `RTC_DS_ONE) || (diode_f == `RTC_DS_TWO);
   assign next_charger_enable = (unlock_f == `RTC_UNLOCK) && diode_ok && (res_f != `RTC_RS_OFF);
   assign next_charger_two_diodes = (diode_f == `RTC_DS_TWO);

   // Pins come from flops so a flag clear and a select change never glitch them
   always @(posedge clk_sys) begin
      if (rst) begin
         irq_out_first_n <= 1'b1;
         irq_out_second_n <= 1'b1;
         charger_enable <= 1'b0;
         charger_two_diodes <= 1'b0;
         charger_resistor <= `RTC_RS_OFF;
      end else begin
         irq_out_first_n <= next_irq_first_n;
         irq_out_second_n <= next_irq_second_n;
         charger_enable <= next_charger_enable;
         charger_two_diodes <= next_charger_two_diodes;
         charger_resistor <= res_f;
      end
   end
endmodule
`default_nettype wire

// >>> tb/rtc_checker.sv
// Port-level checker for the serial clock block, bound to its top module.
// Assumes one clk_sys domain with synchronous active-high rst.
`default_nettype none
module rtc_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic chip_enable,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic primary_supply_valid,
   input wire logic alarm0_match,
   input wire logic alarm1_match,
   input wire logic irq_out_first_n,
   input wire logic irq_out_second_n,
   input wire logic oscillator_disable,
   input wire logic charger_enable,
   input wire logic ext_we,
   input wire logic ext_re
);
   wire logic any_m = alarm0_match | alarm1_match;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Pins pass a two-flop synchroniser, so a quiet chip enable is trusted after six cycles
   a_oe_released: assert property (!chip_enable [*6] |-> !serial_out_oe)
      else $error("data line driven while deselected");
   a_out_quiet: assert property (!serial_out_oe |-> !serial_out)
      else $error("data out not parked low");
   a_we_pulse: assert property (ext_we |=> !ext_we)
      else $error("write strobe longer than one cycle");
   a_we_supply: assert property (!primary_supply_valid [*2] |-> !ext_we)
      else $error("write issued without valid supply");
   a_ext_selected: assert property (ext_we || ext_re |-> chip_enable && !(ext_we && ext_re))
      else $error("external access outside a transfer");
   a_ctrl_quiet: assert property (!chip_enable [*6] |-> $stable(oscillator_disable) && $stable(charger_enable))
      else $error("control outputs moved while idle");
   a_irq0_cause: assert property ($fell(irq_out_first_n) |-> chip_enable || $past(any_m) || $past(any_m, 2) || $past(any_m, 3))
      else $error("first interrupt without cause");
   a_irq1_cause: assert property ($fell(irq_out_second_n) |-> chip_enable || $past(alarm1_match, 2) || $past(alarm1_match, 3))
      else $error("second interrupt without cause");
   a_irq_clear: assert property ($rose(irq_out_first_n) || $rose(irq_out_second_n) |-> chip_enable)
      else $error("interrupt released without access");
   c_write: cover property (ext_we);
   c_read_out: cover property ($rose(serial_out_oe));
   c_irq_second: cover property ($fell(irq_out_second_n));
endmodule
bind rtc_serial_top rtc_checker u_rtc_checker (.clk_sys, .rst, .chip_enable, .serial_out, .serial_out_oe,
   .primary_supply_valid, .alarm0_match, .alarm1_match, .irq_out_first_n, .irq_out_second_n,
   .oscillator_disable, .charger_enable, .ext_we, .ext_re);
`default_nettype wire

// >>> tb/rtc_host.sv
// Host model: bus master on chip enable, serial clock and data in.
// Assumes tb_top calls its tasks; the clock stands at idle between frames.
`default_nettype none
module rtc_host (
   input wire logic clk_sys,
   input wire logic serial_out,
   output logic chip_enable = 1'b0,
   output logic sclk = 1'b0,
   output logic serial_in = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pol = 1'b0, lsb = 1'b0;
   task automatic half();
      repeat (10) @(negedge clk_sys);
   endtask
   task automatic open_ce();
      sclk = pol;
      half();
      chip_enable = 1'b1;
      half();
   endtask
   task automatic close_ce();
      half();
      chip_enable = 1'b0;
      serial_in = ~serial_in;
      half();
   endtask
   // Data is held over both edges, so one loop serves either strobe edge
   task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         serial_in = tx[lsb ? 7 - i : i];
         sclk = ~pol;
         half();
         rx[lsb ? 7 - i : i] = serial_out;
         sclk = pol;
         half();
      end
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Bench: host model drives the pins, an array stands behind ext_*.
// Assumes rtc_host and the bound checker are compiled with the design.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, rst = 1'b1, interface_select_strap = 1'b1;
   logic primary_supply_valid = 1'b1, alarm0_match = 1'b0, alarm1_match = 1'b0;
   wire chip_enable, sclk, serial_in, host_in, serial_out, serial_out_oe, irq_out_first_n, irq_out_second_n;
   wire oscillator_disable, charger_enable, charger_two_diodes, ext_we, ext_re, line_out;
   wire [1:0] charger_resistor;
   wire [6:0] ext_addr;
   wire [7:0] ext_wdata, ext_rdata;
   logic [7:0] ext_mem [0:127], exp_mem [0:127], wq [$], ctrl_m = 8'h80, chg_m = 8'h5c;
   logic [1:0] flg = 2'b00;
   int num_errors = 0, cmp_count = 0, seed = 32'hb2864ebf;
   rtc_host u_rtc_host (.clk_sys, .serial_out(line_out), .chip_enable, .sclk, .serial_in(host_in));
   rtc_serial_top u_rtc_serial_top (.clk_sys, .rst, .chip_enable, .sclk, .serial_in, .serial_out, .serial_out_oe,
      .interface_select_strap, .primary_supply_valid, .alarm0_match, .alarm1_match, .irq_out_first_n,
      .irq_out_second_n, .oscillator_disable, .charger_enable, .charger_two_diodes, .charger_resistor,
      .ext_addr, .ext_wdata, .ext_we, .ext_re, .ext_rdata);
   // In 3-wire mode the device and host share one line
   assign serial_in = (!interface_select_strap && serial_out_oe) ? serial_out : host_in;
   // A released line floats high, opposite to the parked level, so a missing enable shows
   assign line_out = serial_out_oe ? serial_out : 1'b1;
   assign ext_rdata = ext_mem[ext_addr];
   always @(posedge clk_sys) if (ext_we) ext_mem[ext_addr] <= ext_wdata;
   initial forever #2 clk_sys = ~clk_sys;
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      cmp_count++;
      if (seen !== want) begin
         num_errors++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   function automatic logic [1:0] keep(input logic [6:0] p);
      return ~{p >= 7'h0b && p <= 7'h0e, p >= 7'h07 && p <= 7'h0a};
   endfunction
   task automatic model_wr(input logic [6:0] p, input logic [7:0] d);
      if (primary_supply_valid) begin
         if (p == 7'h0f) ctrl_m = ctrl_m[6] ? {ctrl_m[7], d[6], ctrl_m[5:0]} : d & 8'hc7;
         else if (!ctrl_m[6] && p == 7'h11) chg_m = d;
         else if (!ctrl_m[6] && p != 7'h10) exp_mem[p] = d;
      end
   endtask
   task automatic chk_pins();
      logic en;
      en = chg_m[7:4] == 4'ha && (chg_m[3:2] == 2'h1 || chg_m[3:2] == 2'h2) && chg_m[1:0] != 2'h0;
      check(oscillator_disable, ctrl_m[7]);
      check(charger_enable, en);
      check(charger_resistor, chg_m[1:0]);
      if (en) check(charger_two_diodes, chg_m[3]);
      check(irq_out_first_n, !(flg[0] && ctrl_m[0] || !ctrl_m[2] && flg[1] && ctrl_m[1]));
      check(irq_out_second_n, !(ctrl_m[2] && flg[1] && ctrl_m[1]));
   endtask
   task automatic acc(input logic [7:0] a, input int n);
      logic [7:0] r;
      logic [6:0] p;
      p = a[6:0];
      u_rtc_host.open_ce();
      u_rtc_host.byte_io(a, r);
      for (int k = 0; k < n; k++) begin
         flg = flg & keep(p);
         u_rtc_host.byte_io(a[7] ? wq[k] : 8'($random(seed)), r);
         if (a[7]) model_wr(p, wq[k]);
         else check(r, p == 7'h0f ? ctrl_m : p == 7'h10 ? {6'h00, flg} : p == 7'h11 ? chg_m : exp_mem[p]);
         p = p == 7'h1f ? 7'h00 : p == 7'h7f ? 7'h20 : p + 7'h01;
      end
      flg = flg & keep(p);
      u_rtc_host.close_ce();
      chk_pins();
   endtask
   task automatic hit(input logic [1:0] m);
      {alarm1_match, alarm0_match} = m;
      @(negedge clk_sys);
      {alarm1_match, alarm0_match} = 2'b00;
      flg = flg | m;
      repeat (4) @(negedge clk_sys);
      chk_pins();
   endtask
   task automatic print_verdict();
      $display("compares=%0d mismatches=%0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #300000;
      num_errors++;
      print_verdict();
   end
   initial begin
      for (int i = 0; i < 128; i++) begin
         ext_mem[i] = 8'(i) ^ 8'h5a;
         exp_mem[i] = 8'(i) ^ 8'h5a;
      end
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      check(serial_out_oe, 1'b0);
      chk_pins();
      acc(8'h0f, 3);
      wq = {8'h00};
      acc(8'h8f, 1);
      $display("reset test done");
      for (int i = 0; i < 10; i++) begin
         wq = {i < 6 ? {4'ha, 2'(i / 3 + 1), 2'(i % 3 + 1)} : 8'($random(seed))};
         acc(8'h91, 1);
         acc(8'h11, 1);
      end
      $display("charger test done");
      for (int c = 0; c < 8; c++) begin
         wq = {8'(c)};
         acc(8'h8f, 1);
         hit(2'b11);
         acc(8'h10, 1);
         acc(8'h07, 1);
         acc(8'h10, 1);
         acc(8'h0e, 1);
      end
      $display("alarm test done");
      wq = {8'h40};
      acc(8'h8f, 1);
      wq = {8'hc7, 8'h00, 8'ha5};
      acc(8'h8f, 3);
      wq = {8'h33};
      acc(8'ha0, 1);
      acc(8'h0f, 3);
      acc(8'h20, 1);
      wq = {8'h00};
      acc(8'h8f, 1);
      $display("protect test done");
      primary_supply_valid = 1'b0;
      wq = {8'h87, 8'h00, 8'haa};
      acc(8'h8f, 3);
      primary_supply_valid = 1'b1;
      acc(8'h0f, 3);
      $display("supply test done");
      wq = {};
      repeat (3) wq.push_back(8'($random(seed)));
      acc(8'hfe, 3);
      acc(8'h7e, 3);
      acc(8'h9f, 2);
      acc(8'h1f, 2);
      $display("burst test done");
      {interface_select_strap, u_rtc_host.lsb} = 2'b01;
      wq = {8'h05};
      acc(8'h8f, 1);
      acc(8'h0f, 1);
      {interface_select_strap, u_rtc_host.lsb} = 2'b10;
      u_rtc_host.pol = 1'b1;
      acc(8'h0f, 1);
      $display("mode test done");
      rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      {ctrl_m, chg_m, flg} = {8'h80, 8'h5c, 2'b00};
      repeat (2) @(negedge clk_sys);
      check(serial_out_oe, 1'b0);
      chk_pins();
      acc(8'h0f, 3);
      $display("second reset test done");
      print_verdict();
   end
endmodule
`default_nettype wire
